// ===== rtl/asa_core.sv
// Purpose: async serial adapter core, bus side registers plus tx and rx engines
// Assumes: bus and serial pins, tx and rx clocks are sampled through two flops
// Notes:   serial bit clocks are sampled, so each clock edge costs 3 sys_clk cycles latency
// Summary of operation
// - cts high forces tx empty low
// - carrier lost holds receiver reset, rx empty
// - carrier rising edge interrupts when enabled
// - data write on enable fall clears tx empty
// - holding moves to shifter, sets tx empty
// - complete char loads empty rx holding
// - data read clears rx full, keeps data
// - control bits 1:0 pick divider
// - master reset clears status, not control
// - control bits 4:2 pick frame format
// - format changes act immediately
// - control bits 6:5 drive rts, break, tx irq
// - control bit 7 enables rx irqs
// - select and direction pick register
// - status byte bit layout
// - carrier status latches until data read
// - framing error on missing first stop
// - overrun shows after earlier char read
// - parity error checks; none suppresses parity
// - irq status mirrors irq output
// - seven-bit modes strip bit 7
// - start, lsb first, parity, stops
// - start needs 1, 8 or 32 low samples
// - tx on falling, rx on rising clock
// - first master reset holds rts high
`timescale 1ns/10ps
module asa_core (
  // system
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // processor bus
  input  wire logic       bus_en,
  input  wire logic       chip_sel,
  input  wire logic       register_pick,
  input  wire logic       rd_wr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            irq_b,
  // serial side
  input  wire logic       tx_clk,
  input  wire logic       rx_clk,
  input  wire logic       rx_data,
  output logic            tx_data,
  input  wire logic       cts_b,
  input  wire logic       carrier_lost,
  output logic            rts_b
);
  // synchronised pins
  logic en_s, cs_s, rp_s, rw_s, txc_s, rxc_s, rxd_s, cts_s, dcd_s;
  logic [7:0] din_s;
  logic en_fall, txc_fall, rxc_rise, dcd_rise;

  asa_sync u_s_en  (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(bus_en),        .pin_sync(en_s));
  asa_sync u_s_cs  (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(chip_sel),      .pin_sync(cs_s));
  asa_sync u_s_rp  (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(register_pick), .pin_sync(rp_s));
  asa_sync u_s_rw  (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(rd_wr),         .pin_sync(rw_s));
  asa_sync u_s_txc (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(tx_clk),        .pin_sync(txc_s));
  asa_sync u_s_rxc (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(rx_clk),        .pin_sync(rxc_s));
  asa_sync u_s_rxd (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(rx_data),       .pin_sync(rxd_s));
  asa_sync u_s_cts (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(cts_b),         .pin_sync(cts_s));
  asa_sync u_s_dcd (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(carrier_lost),  .pin_sync(dcd_s));

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_din
      asa_sync u_s_d (.sys_clk(sys_clk), .rst_b(rst_b), .pin_in(data_in[gi]),
                      .pin_sync(din_s[gi]));
    end
  endgenerate

  asa_edge u_e_en  (.sys_clk(sys_clk), .rst_b(rst_b), .lvl(en_s),  .rise(),         .fall(en_fall));
  asa_edge u_e_txc (.sys_clk(sys_clk), .rst_b(rst_b), .lvl(txc_s), .rise(),         .fall(txc_fall));
  asa_edge u_e_rxc (.sys_clk(sys_clk), .rst_b(rst_b), .lvl(rxc_s), .rise(rxc_rise), .fall());
  asa_edge u_e_dcd (.sys_clk(sys_clk), .rst_b(rst_b), .lvl(dcd_s), .rise(dcd_rise), .fall());

  typedef struct packed {
    logic [7:0]          ctl;
    logic                first_rst;
    logic [7:0]          thr;
    logic                thr_empty;
    asa_pkg::asa_phase_t tx_ph;
    logic [9:0]          tx_sh;
    logic [3:0]          tx_left;
    logic [6:0]          tx_div;
    logic [7:0]          rhr;
    logic                rhr_full;
    logic                fe;
    logic                pe;
    logic                ovr_pend;
    logic                ovr;
    logic                dcd_lat;
    logic                dcd_seen;
    asa_pkg::asa_phase_t rx_ph;
    logic [8:0]          rx_sh;
    logic [3:0]          rx_cnt;
    logic [6:0]          rx_div;
    logic [7:0]          dout;
    logic                oe;
    logic                irq_n;
    logic                rts_n;
    logic                txd;
  } asa_state_t;

  asa_state_t st_q;
  asa_state_t st_d;

  logic       mreset;
  logic [1:0] txc;
  logic [2:0] fmt;
  logic       fmt8, par_on, par_odd, two_stop;
  logic [6:0] ratio;
  logic       wr_acc, rd_acc;
  logic [7:0] status;
  logic       tx_empty_vis, irq_cond;
  logic       tx_tick, rx_tick, rx_mid;
  logic [3:0] nbits;
  logic       rx_bit;

  always_comb begin
    mreset   = (st_q.ctl[asa_pkg::CTL_DIV_HI:asa_pkg::CTL_DIV_LO] == asa_pkg::DIV_MRESET);
    txc      = st_q.ctl[asa_pkg::CTL_TXC_HI:asa_pkg::CTL_TXC_LO];
    fmt      = st_q.ctl[asa_pkg::CTL_FMT_HI:asa_pkg::CTL_FMT_LO];
    fmt8     = fmt[2];
    par_on   = !(fmt == 3'h4 || fmt == 3'h5);
    par_odd  = fmt[0];
    two_stop = (fmt == 3'h0 || fmt == 3'h1 || fmt == 3'h4);
    nbits    = fmt8 ? 4'h8 : 4'h7;
    unique case (st_q.ctl[asa_pkg::CTL_DIV_HI:asa_pkg::CTL_DIV_LO])
      asa_pkg::DIV_BY_16: ratio = asa_pkg::RATIO_16;
      asa_pkg::DIV_BY_64: ratio = asa_pkg::RATIO_64;
      default:            ratio = 7'h01;
    endcase
    // register decode, taken on enable fall
    wr_acc = en_fall && cs_s && !rw_s;
    rd_acc = en_fall && cs_s && rw_s;
    tx_empty_vis = st_q.thr_empty && !cts_s && !mreset;
    irq_cond = (tx_empty_vis && txc == asa_pkg::TXC_RTS_LO_IRQ)
             || (st_q.ctl[asa_pkg::CTL_RX_IRQ_EN]
                 && ((st_q.rhr_full && !dcd_s) || st_q.ovr || st_q.dcd_seen));
    status = '0;
    status[asa_pkg::ST_RX_FULL]  = st_q.rhr_full && !dcd_s;
    status[asa_pkg::ST_TX_EMPTY] = tx_empty_vis;
    status[asa_pkg::ST_CARRIER]  = st_q.dcd_lat || dcd_s;
    status[asa_pkg::ST_CTS]      = cts_s;
    status[asa_pkg::ST_FRAME]    = st_q.fe;
    status[asa_pkg::ST_OVERRUN]  = st_q.ovr;
    status[asa_pkg::ST_PARITY]   = st_q.pe;
    status[asa_pkg::ST_IRQ]      = !st_q.irq_n;
    // divide by one: every edge is a tick
    tx_tick = txc_fall && (st_q.tx_div == 7'h00);
    rx_tick = rxc_rise;
    rx_mid  = rx_tick && (st_q.rx_div == ratio - 7'h01);
    rx_bit  = rxd_s;

    st_d = st_q;
    st_d.oe = en_s && cs_s && rw_s;
    st_d.dout = rp_s ? st_q.rhr : status;

    if (wr_acc && !rp_s) begin
      st_d.ctl = din_s;
    end
    if (wr_acc && rp_s) begin
      // bit 7 ignored in seven-bit modes
      st_d.thr       = fmt8 ? din_s : {1'b0, din_s[6:0]};
      st_d.thr_empty = 1'b0;
    end
    // status read leaves the carrier latches unchanged
    if (rd_acc && !rp_s && st_q.dcd_lat) begin
      st_d.dcd_seen = st_q.dcd_seen;
    end
    if (rd_acc && rp_s) begin
      // read clears full, data kept
      // a pending overrun keeps full set until the overrun itself is read away
      st_d.rhr_full = st_q.ovr_pend && !st_q.ovr;
      st_d.ovr      = st_q.ovr_pend && !st_q.ovr;
      st_d.ovr_pend = 1'b0;
      if (st_q.ovr) begin
        st_d.rhr_full = 1'b0;
      end
      if (st_q.dcd_lat) begin
        st_d.dcd_lat  = 1'b0;
        st_d.dcd_seen = 1'b0;
      end
    end
    // carrier edge latches, set wins over clear
    if (dcd_rise) begin
      st_d.dcd_lat  = 1'b1;
      st_d.dcd_seen = 1'b1;
    end

    // transmitter
    if (tx_tick || (txc_fall && ratio != 7'h01)) begin
      st_d.tx_div = (st_q.tx_div == ratio - 7'h01) ? 7'h00 : st_q.tx_div + 7'h01;
    end
    if (tx_tick) begin
      unique case (st_q.tx_ph)
        asa_pkg::ASA_IDLE: begin
          st_d.txd = 1'b1;
          // idle load within one bit time
          if (!st_q.thr_empty && !st_d.thr_empty) begin
            st_d.thr_empty = 1'b1;
            st_d.tx_sh     = {1'b1, (par_odd ^ ~^st_q.thr[7:0]) ^ 1'b1, st_q.thr};
            if (!fmt8) begin
              st_d.tx_sh = {2'b11, par_odd ^ ~^st_q.thr[6:0] ^ 1'b1, st_q.thr[6:0]};
            end
            if (!par_on) begin
              st_d.tx_sh = {2'b11, st_q.thr};
            end
            st_d.tx_left = nbits + (par_on ? 4'h1 : 4'h0);
            st_d.txd     = 1'b0;
            st_d.tx_ph   = asa_pkg::ASA_DATA;
          end
        end
        asa_pkg::ASA_DATA: begin
          st_d.txd     = st_q.tx_sh[0];
          st_d.tx_sh   = {1'b1, st_q.tx_sh[9:1]};
          st_d.tx_left = st_q.tx_left - 4'h1;
          if (st_q.tx_left == 4'h1) begin
            st_d.tx_ph   = asa_pkg::ASA_STOP;
            st_d.tx_left = two_stop ? 4'h2 : 4'h1;
          end
        end
        asa_pkg::ASA_STOP: begin
          st_d.txd     = 1'b1;
          st_d.tx_left = st_q.tx_left - 4'h1;
          if (st_q.tx_left == 4'h1) begin
            st_d.tx_ph = asa_pkg::ASA_IDLE;
          end
        end
        default: st_d.tx_ph = asa_pkg::ASA_IDLE;
      endcase
    end
    if (txc == asa_pkg::TXC_BREAK) begin
      st_d.txd = 1'b0;
    end

    // receiver
    if (rx_tick) begin
      st_d.rx_div = (st_q.rx_div == ratio - 7'h01) ? 7'h00 : st_q.rx_div + 7'h01;
      unique case (st_q.rx_ph)
        asa_pkg::ASA_IDLE: begin
          st_d.rx_div = 7'h00;
          st_d.rx_cnt = 4'h0;
          if (!rx_bit) begin
            st_d.rx_div = st_q.rx_div + 7'h01;
            if (ratio == 7'h01) begin
              // divider must sit at zero so every edge is a bit centre
              st_d.rx_div = 7'h00;
              st_d.rx_ph  = asa_pkg::ASA_DATA;
            end else if (st_q.rx_div + 7'h01 == (ratio >> 1)) begin
              st_d.rx_div = 7'h00;
              st_d.rx_ph  = asa_pkg::ASA_DATA;
            end
          end
        end
        asa_pkg::ASA_DATA: begin
          if (rx_mid) begin
            st_d.rx_sh  = {rx_bit, st_q.rx_sh[8:1]};
            st_d.rx_cnt = st_q.rx_cnt + 4'h1;
            if (st_q.rx_cnt + 4'h1 == nbits + (par_on ? 4'h1 : 4'h0)) begin
              st_d.rx_ph = asa_pkg::ASA_STOP;
            end
          end
        end
        asa_pkg::ASA_STOP: begin
          if (rx_mid) begin
            st_d.rx_ph = asa_pkg::ASA_IDLE;
            if (!st_q.rhr_full) begin
              st_d.rhr_full = 1'b1;
              st_d.rhr = fmt8 ? (par_on ? st_q.rx_sh[7:0] : st_q.rx_sh[8:1])
                              : {1'b0, st_q.rx_sh[7:1]};
              st_d.fe = !rx_bit;
              // parity check, odd means odd ones
              st_d.pe = par_on && ((^st_q.rx_sh[8:0] ^ (fmt8 ? 1'b0 : st_q.rx_sh[0]))
                                   != par_odd);
            end else begin
              st_d.ovr_pend = 1'b1;
            end
          end
        end
        default: st_d.rx_ph = asa_pkg::ASA_IDLE;
      endcase
    end
    if (dcd_s) begin
      st_d.rx_ph  = asa_pkg::ASA_IDLE;
      st_d.rx_div = 7'h00;
    end

    if (mreset) begin
      st_d.thr_empty = 1'b1;
      st_d.rhr_full  = 1'b0;
      st_d.fe        = 1'b0;
      st_d.pe        = 1'b0;
      st_d.ovr       = 1'b0;
      st_d.ovr_pend  = 1'b0;
      st_d.dcd_lat   = 1'b0;
      st_d.dcd_seen  = 1'b0;
      st_d.tx_ph     = asa_pkg::ASA_IDLE;
      st_d.rx_ph     = asa_pkg::ASA_IDLE;
      st_d.tx_div    = 7'h00;
      st_d.rx_div    = 7'h00;
      st_d.txd       = 1'b1;
    end
    if (wr_acc && !rp_s && din_s[1:0] != asa_pkg::DIV_MRESET) begin
      st_d.first_rst = 1'b0;
    end
    // irq cleared by data access through source flags
    st_d.irq_n = mreset ? 1'b1 : !irq_cond;
    st_d.rts_n = (mreset && st_q.first_rst) ? 1'b1 : (txc == asa_pkg::TXC_RTS_HI_NOIRQ);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q           <= '0;
      st_q.ctl       <= asa_pkg::CTL_RESET_VAL;
      st_q.first_rst <= 1'b1;
      st_q.thr_empty <= 1'b1;
      st_q.irq_n     <= 1'b1;
      st_q.rts_n     <= 1'b1;
      st_q.txd       <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign data_out = st_q.dout;
  assign data_oe  = st_q.oe;
  assign irq_b    = st_q.irq_n;
  assign rts_b    = st_q.rts_n;
  assign tx_data  = st_q.txd;

  property p_irq_mirror;
    @(posedge sys_clk) disable iff (!rst_b)
      (st_q.oe && !rp_s) |=> (st_q.dout[asa_pkg::ST_IRQ] == !$past(st_q.irq_n));
  endproperty
  a_irq_mirror: assert property (p_irq_mirror) else $error("irq status mismatch");

  property p_wr_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      (wr_acc && rp_s && !mreset) |=> !st_q.thr_empty || tx_tick;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("tx empty not cleared");

  property p_mreset;
    @(posedge sys_clk) disable iff (!rst_b)
      mreset ##1 mreset |-> st_q.thr_empty && !st_q.ovr && !st_q.fe && !st_q.pe;
  endproperty
  a_mreset: assert property (p_mreset) else $error("master reset left flags");

  property p_irq_rst;
    @(posedge sys_clk) disable iff (!rst_b) mreset |=> st_q.irq_n;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq active in master reset");

  property p_break;
    @(posedge sys_clk) disable iff (!rst_b)
      (txc == asa_pkg::TXC_BREAK && !mreset) |=> !st_q.txd;
  endproperty
  a_break: assert property (p_break) else $error("break not on line");

  property p_dcd_idle;
    @(posedge sys_clk) disable iff (!rst_b) dcd_s |=> st_q.rx_ph == asa_pkg::ASA_IDLE;
  endproperty
  a_dcd_idle: assert property (p_dcd_idle) else $error("receiver active without carrier");

  property p_dcd_lat;
    @(posedge sys_clk) disable iff (!rst_b) (dcd_rise && !mreset) |=> st_q.dcd_lat;
  endproperty
  a_dcd_lat: assert property (p_dcd_lat) else $error("carrier loss not latched");

  // data read clears full, keeps data
  property p_rd_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      (rd_acc && rp_s && !st_q.ovr && !st_q.ovr_pend && !rx_mid)
        |=> !st_q.rhr_full && $stable(st_q.rhr);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not clear full");

endmodule : asa_core

// ===== rtl/asa_edge.sv
// Purpose: edge detector on a synchronised level
// Assumes: input already synchronised to sys_clk
// Notes:   one-cycle pulses for rising and falling edges
`timescale 1ns/10ps
module asa_edge (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // level and edges
  input  wire logic lvl,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic prev;
  } asa_edge_t;

  asa_edge_t st_q;
  asa_edge_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.prev = lvl;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = lvl & ~st_q.prev;
  assign fall = ~lvl & st_q.prev;
endmodule : asa_edge

// ===== rtl/asa_pkg.sv
// Purpose: shared constants for the async serial adapter core
// Assumes: single 100 MHz system clock, bus and serial pins synchronised inside
// Notes:   control and status bit positions, divider codes, frame codes
package asa_pkg;

  // control register fields
  localparam int CTL_DIV_LO     = 0;
  localparam int CTL_DIV_HI     = 1;
  localparam int CTL_FMT_LO     = 2;
  localparam int CTL_FMT_HI     = 4;
  localparam int CTL_TXC_LO     = 5;
  localparam int CTL_TXC_HI     = 6;
  localparam int CTL_RX_IRQ_EN  = 7;
  localparam logic [7:0] CTL_RESET_VAL = 8'h03;

  // divide select codes
  localparam logic [1:0] DIV_BY_1   = 2'h0;
  localparam logic [1:0] DIV_BY_16  = 2'h1;
  localparam logic [1:0] DIV_BY_64  = 2'h2;
  localparam logic [1:0] DIV_MRESET = 2'h3;

  // oversample ratios and start qualification counts
  localparam logic [6:0] RATIO_16    = 7'h10;
  localparam logic [6:0] RATIO_64    = 7'h40;
  localparam logic [6:0] START_Q_16  = 7'h08;
  localparam logic [6:0] START_Q_64  = 7'h20;

  // transmit control codes
  localparam logic [1:0] TXC_RTS_LO_NOIRQ = 2'h0;
  localparam logic [1:0] TXC_RTS_LO_IRQ   = 2'h1;
  localparam logic [1:0] TXC_RTS_HI_NOIRQ = 2'h2;
  localparam logic [1:0] TXC_BREAK        = 2'h3;

  // status register bits
  localparam int ST_RX_FULL  = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_CARRIER  = 2;
  localparam int ST_CTS      = 3;
  localparam int ST_FRAME    = 4;
  localparam int ST_OVERRUN  = 5;
  localparam int ST_PARITY   = 6;
  localparam int ST_IRQ      = 7;

  typedef enum logic [1:0] {
    ASA_IDLE  = 2'h0,
    ASA_START = 2'h1,
    ASA_DATA  = 2'h3,
    ASA_STOP  = 2'h2
  } asa_phase_t;

endpackage : asa_pkg

// ===== rtl/asa_sync.sv
// Purpose: two flip-flop synchroniser for one asynchronous pin
// Assumes: pin is unrelated to sys_clk
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
module asa_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // pin and synchronised level
  input  wire logic pin_in,
  output logic      pin_sync
);
  typedef struct packed {
    logic s1;
    logic s2;
  } asa_sync_t;

  asa_sync_t st_q;
  asa_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_sync = st_q.s2;
endmodule : asa_sync

// ===== verification/asa_modem.sv
// Purpose: behavioural far-end peripheral for the async serial adapter core
// Assumes: serial clock period far above the system clock period
// Notes:   one free running clock feeds both the transmit and receive clock pins
`timescale 1ns/10ps
module asa_modem (
  // serial clocks
  output logic      tx_clk,
  output logic      rx_clk,
  // serial lines
  output logic      rx_data,
  input  wire logic tx_data
);
  int q[$];
  int sh;
  int cnt;

  initial begin
    rx_clk  = 1'b0;
    rx_data = 1'b1;
    cnt     = -1;
    forever #80 rx_clk = ~rx_clk;
  end
  assign tx_clk = rx_clk;

  always @(posedge tx_clk) begin
    if (cnt < 0) begin
      if (tx_data === 1'b0) begin
        cnt = 0;
        sh  = 0;
      end
    end else begin
      sh[cnt] = tx_data;
      cnt++;
      if (cnt == 9) begin
        q.push_back(sh);
        cnt = -1;
      end
    end
  end

  // start, frame bits, idle high; r clocks per bit
  task send(input int b, input int r);
    int c;
    c = (b << 1) | 2048;
    @(negedge rx_clk);
    for (int i = 0; i < 12; i++) begin
      rx_data = c[i];
      repeat (r) @(negedge rx_clk);
    end
  endtask : send

  // short low pulse that must not start a character
  task glitch(input int n);
    @(negedge rx_clk);
    rx_data = 1'b0;
    repeat (n) @(negedge rx_clk);
    rx_data = 1'b1;
  endtask : glitch
endmodule : asa_modem

// ===== verification/async_serial_adapter_core_tb.sv
// Purpose: self-checking bench for the async serial adapter core
// Assumes: bus accesses held well past the three-flop input latency
// Notes:   expected frames and status bytes are built from integers here
`timescale 1ns/10ps
module async_serial_adapter_core_tb;
  logic       sys_clk, rst_b, bus_en, chip_sel, register_pick, rd_wr, data_oe;
  logic       irq_b, tx_clk, rx_clk, rx_data, tx_data, cts_b, carrier_lost, rts_b;
  logic [7:0] data_in, data_out, v;
  logic       o;
  int         fail_count, comparisons, d, k, f, m;

  asa_core asa_core_inst (.sys_clk, .rst_b, .bus_en, .chip_sel, .register_pick,
    .rd_wr, .data_in, .data_out, .data_oe, .irq_b, .tx_clk, .rx_clk, .rx_data,
    .tx_data, .cts_b, .carrier_lost, .rts_b);
  asa_modem modem (.tx_clk, .rx_clk, .rx_data, .tx_data);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // bits after the start bit: data lsb first, parity, stops, then idle ones
  function automatic int frm(input int fm, input int x);
    int n, r, p;
    n = fm[2] ? 8 : 7;
    r = x & ((1 << n) - 1);
    if (fm != 4 && fm != 5) begin
      p = (^r) ^ fm[0];
      r = r | (p << n);
      n++;
    end
    return r | (1023 & ~((1 << n) - 1));
  endfunction : frm

  task automatic chk(input string n, input int e, input logic [9:0] s);
    comparisons++;
    if (s !== 10'(e)) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // hold the access across the input flops, capture read data while enabled
  task automatic bus(input logic rp, input logic rw, input logic [7:0] w);
    tick(1);
    register_pick = rp;
    rd_wr = rw;
    data_in = w;
    chip_sel = 1'b1;
    bus_en = 1'b1;
    tick(6);
    v = data_out;
    o = data_oe;
    bus_en = 1'b0;
    tick(6);
    chip_sel = 1'b0;
  endtask : bus

  task automatic st(input int e);
    bus(1'b0, 1'b1, 8'h00);
    chk("status", e, v);
    chk("data_oe", 2, {o, data_oe});
  endtask : st

  task automatic rd(input int e);
    bus(1'b1, 1'b1, 8'h00);
    chk("rx_data", e, v);
  endtask : rd

  task end_of_test;
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #800000;
    fail_count++;
    end_of_test;
  end

  initial begin
    {bus_en, chip_sel, register_pick, rd_wr, cts_b, carrier_lost, rst_b} = 7'h08;
    data_in = 8'h00;
    fail_count = 0;
    comparisons = 0;
    d = $urandom(47660);
    tick(20);
    rst_b = 1'b1;
    tick(4);
    chk("rts_irq", 3, {rts_b, irq_b});
    bus(1'b0, 1'b0, 8'h03);
    for (f = 0; f < 8; f++) begin
      m = f[2] ? 255 : 127;
      d = $urandom & 255;
      bus(1'b0, 1'b0, 8'(f << 2));
      st(2);
      bus(1'b1, 1'b0, 8'(d));
      for (k = 0; k < 600 && modem.q.size() == 0; k++) tick(1);
      chk("tx_frame", frm(f, d) & 511, modem.q.size() ? modem.q.pop_front() : 0);
      d = $urandom & 255;
      modem.send(frm(f, d), 1);
      tick(10);
      st(3);
      rd(d & m);
      st(2);
    end
    bus(1'b0, 1'b0, 8'h1c);
    for (k = 256; k < 1024; k *= 2) begin
      modem.send(frm(7, 8'h5a) ^ k, 1);
      tick(10);
      st(k == 256 ? 8'h43 : 8'h13);
      rd(8'h5a);
    end
    bus(1'b0, 1'b0, 8'h14);
    modem.send(frm(5, 8'ha5), 1);
    modem.send(frm(5, 8'h3c), 1);
    tick(10);
    st(3);
    rd(8'ha5);
    st(8'h23);
    bus(1'b1, 1'b1, 8'h00);
    st(2);
    cts_b = 1'b1;
    tick(8);
    st(8'h08);
    cts_b = 1'b0;
    for (k = 0; k < 4; k++) begin
      bus(1'b0, 1'b0, 8'((k << 5) | 8'h14));
      tick(40);
      chk("rts_irq_tx", {k == 2, k != 1, k != 3}, {rts_b, irq_b, tx_data});
    end
    bus(1'b0, 1'b0, 8'h94);
    tick(400);
    modem.q.delete();
    carrier_lost = 1'b1;
    tick(10);
    chk("irq_b", 0, irq_b);
    modem.send(frm(5, 8'h11), 1);
    tick(10);
    st(8'h86);
    carrier_lost = 1'b0;
    tick(10);
    st(8'h86);
    bus(1'b1, 1'b1, 8'h00);
    st(2);
    chk("irq_b", 1, irq_b);
    modem.send(frm(5, 8'h77), 1);
    tick(10);
    chk("irq_b", 0, irq_b);
    st(8'h83);
    rd(8'h77);
    chk("irq_b", 1, irq_b);
    modem.send(frm(5, 8'h42), 1);
    tick(10);
    bus(1'b0, 1'b0, 8'h03);
    bus(1'b0, 1'b0, 8'h14);
    st(2);
    for (k = 1; k < 3; k++) begin
      m = k == 1 ? 16 : 64;
      bus(1'b0, 1'b0, 8'(8'h14 | k));
      modem.glitch(m / 4);
      tick(10);
      st(2);
      modem.send(frm(5, m + 5), m);
      tick(10);
      st(3);
      rd(m + 5);
    end
    end_of_test;
  end
endmodule : async_serial_adapter_core_tb
